// ==== pcr_pkg.sv ====
// package: register map, fields, resets and encodings for the channel 2/3 configuration bank
// Notes on behaviour
// (R1) channel 2 source select is bits 6-5 of its input register: 0 off, 2 pdm microphone, 1 and 3 reserved.
// (R2) channel 2 in pdm mode takes its bitstream from pdm data line 1 against the shared pdm clock.
// (R3) channel 3 source select uses the same 2-bit code in bits 6-5.
// (R4) channel 3 in pdm mode takes its bitstream from pdm data line 2 against the shared pdm clock.
// (R5) volume code 0 mutes, codes 1 to 255 step 0.5 dB from -100 dB through 0 dB at 201 to 27 dB.
// (R6) the channel 2 volume register resets to c9h, unity gain.
// (R7) gain trim in bits 7-4 applies (code minus 8) times 0.1 dB.
// (R8) the gain trim register resets to 80h and its low four bits read zero and ignore writes.
// (R9) the phase trim delays the channel by that many modulator clock cycles, 0 to 255.
// (R10) the channel 2 phase trim register resets to zero.
// (R11) the channel 2 input register resets to zero; bit 7 and bits 4-0 hold zero.
// (R12) the channel 3 input register sits at 46h and resets to zero.
// (R13) the channel 3 volume register sits at 48h and resets to c9h.
// (R14) a reserved source code leaves the channel disabled.
package pcr_pkg;
   localparam logic [7:0] ADDR_CH2_INPUT = 8'h41;
   localparam logic [7:0] ADDR_CH2_VOL   = 8'h43;
   localparam logic [7:0] ADDR_CH2_GAIN  = 8'h44;
   localparam logic [7:0] ADDR_CH2_PHASE = 8'h45;
   localparam logic [7:0] ADDR_CH3_INPUT = 8'h46;
   localparam logic [7:0] ADDR_CH3_VOL   = 8'h48;

   localparam logic [7:0] RST_INPUT = 8'h00;
   localparam logic [7:0] RST_VOL   = 8'hc9;
   localparam logic [7:0] RST_GAIN  = 8'h80;
   localparam logic [7:0] RST_PHASE = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   localparam int SRC_LSB  = 5;
   localparam int SRC_MSB  = 6;
   localparam int GAIN_LSB = 4;
   localparam int GAIN_MSB = 7;

   localparam logic [7:0] MASK_INPUT = 8'h60;
   localparam logic [7:0] MASK_GAIN  = 8'hf0;

   localparam logic [7:0] VOL_MUTE = 8'h00;
   localparam logic [7:0] VOL_UNITY = 8'hc9;
   localparam logic [3:0] GAIN_UNITY = 4'h8;

   typedef enum logic [1:0] {
      PCR_SRC_OFF  = 2'h0,
      PCR_SRC_RES1 = 2'h1,
      PCR_SRC_PDM  = 2'h2,
      PCR_SRC_RES3 = 2'h3
   } pcr_src_e;
endpackage

// ==== pcr_channel_config_regs.sv ====
// register bank for channels 2 and 3 with decoded per-channel controls
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module pcr_channel_config_regs (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdata,
   output logic            chan2Enable,
   output logic            chan2UsesDataLine1,
   output logic            chan2Mute,
   output logic      [7:0] chan2VolumeCode,
   output logic      [3:0] chan2GainTrimCode,
   output logic      [7:0] chan2PhaseDelayCode,
   output logic            chan3Enable,
   output logic            chan3UsesDataLine2,
   output logic            chan3Mute,
   output logic      [7:0] chan3VolumeCode,
   output logic            pdmClockNeeded
);

   typedef struct packed {
      logic [7:0] ch2Input;
      logic [7:0] ch2Vol;
      logic [7:0] ch2Gain;
      logic [7:0] ch2Phase;
      logic [7:0] ch3Input;
      logic [7:0] ch3Vol;
      logic [7:0] rdata;
      logic       en2;
      logic       en3;
      logic       mute2;
      logic       mute3;
   } pcr_state_s;

   pcr_state_s state_q;
   pcr_state_s state_d;

   // only the pdm code enables; reserved codes fall back to off
   function automatic logic srcIsPdm(input logic [7:0] cfg);
      return cfg[pcr_pkg::SRC_MSB:pcr_pkg::SRC_LSB] == pcr_pkg::PCR_SRC_PDM; // R1 R3 R14
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      state_d.rdata = pcr_pkg::READ_ZERO;
      if (regWrite) begin
         if (regAddr == pcr_pkg::ADDR_CH2_INPUT) begin
            state_d.ch2Input = regWdata & pcr_pkg::MASK_INPUT; // R11
         end else if (regAddr == pcr_pkg::ADDR_CH2_VOL) begin
            state_d.ch2Vol = regWdata; // R5
         end else if (regAddr == pcr_pkg::ADDR_CH2_GAIN) begin
            state_d.ch2Gain = regWdata & pcr_pkg::MASK_GAIN; // R7 R8
         end else if (regAddr == pcr_pkg::ADDR_CH2_PHASE) begin
            state_d.ch2Phase = regWdata; // R9
         end else if (regAddr == pcr_pkg::ADDR_CH3_INPUT) begin
            state_d.ch3Input = regWdata & pcr_pkg::MASK_INPUT; // R12
         end else if (regAddr == pcr_pkg::ADDR_CH3_VOL) begin
            state_d.ch3Vol = regWdata; // R13
         end
      end
      // read data reflects the state before a same-cycle write
      if (regRead) begin
         if (regAddr == pcr_pkg::ADDR_CH2_INPUT) begin
            state_d.rdata = state_q.ch2Input;
         end else if (regAddr == pcr_pkg::ADDR_CH2_VOL) begin
            state_d.rdata = state_q.ch2Vol;
         end else if (regAddr == pcr_pkg::ADDR_CH2_GAIN) begin
            state_d.rdata = state_q.ch2Gain;
         end else if (regAddr == pcr_pkg::ADDR_CH2_PHASE) begin
            state_d.rdata = state_q.ch2Phase;
         end else if (regAddr == pcr_pkg::ADDR_CH3_INPUT) begin
            state_d.rdata = state_q.ch3Input;
         end else if (regAddr == pcr_pkg::ADDR_CH3_VOL) begin
            state_d.rdata = state_q.ch3Vol;
         end else begin
            state_d.rdata = pcr_pkg::READ_ZERO;
         end
      end
      // decoded controls track the registers one cycle behind
      state_d.en2 = srcIsPdm(state_q.ch2Input); // R2 R14
      state_d.en3 = srcIsPdm(state_q.ch3Input); // R4 R14
      state_d.mute2 = state_q.ch2Vol == pcr_pkg::VOL_MUTE; // R5
      state_d.mute3 = state_q.ch3Vol == pcr_pkg::VOL_MUTE; // R5
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q.ch2Input <= pcr_pkg::RST_INPUT; // R11
         state_q.ch2Vol   <= pcr_pkg::RST_VOL; // R6
         state_q.ch2Gain  <= pcr_pkg::RST_GAIN; // R8
         state_q.ch2Phase <= pcr_pkg::RST_PHASE; // R10
         state_q.ch3Input <= pcr_pkg::RST_INPUT; // R12
         state_q.ch3Vol   <= pcr_pkg::RST_VOL; // R13
         state_q.rdata    <= pcr_pkg::READ_ZERO;
         state_q.en2      <= 1'b0;
         state_q.en3      <= 1'b0;
         state_q.mute2    <= 1'b0;
         state_q.mute3    <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      regRdata            = state_q.rdata;
      chan2Enable         = state_q.en2;
      chan2UsesDataLine1  = state_q.en2; // R2
      chan2Mute           = state_q.mute2;
      chan2VolumeCode     = state_q.ch2Vol;
      chan2GainTrimCode   = state_q.ch2Gain[pcr_pkg::GAIN_MSB:pcr_pkg::GAIN_LSB]; // R7
      chan2PhaseDelayCode = state_q.ch2Phase; // R9
      chan3Enable         = state_q.en3;
      chan3UsesDataLine2  = state_q.en3; // R4
      chan3Mute           = state_q.mute3;
      chan3VolumeCode     = state_q.ch3Vol;
      // shared clock runs while either channel listens
      pdmClockNeeded      = state_q.en2 | state_q.en3; // R2 R4
   end

endmodule

// ==== pcr_sva.sv ====
// port assertions for the channel 2/3 configuration bank
`timescale 1ns/1ps
module pcr_sva (
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic       chan2Enable,
   input wire logic       chan2UsesDataLine1,
   input wire logic       chan2Mute,
   input wire logic       chan3Enable,
   input wire logic       chan3UsesDataLine2,
   input wire logic       chan3Mute,
   input wire logic       pdmClockNeeded,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic [7:0] chan2VolumeCode,
   input wire logic [7:0] chan2PhaseDelayCode,
   input wire logic [7:0] chan3VolumeCode,
   input wire logic [3:0] chan2GainTrimCode
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_read_idle: assert property (!regRead |=> regRdata == 8'h00) else $error("rdata");
   a_gain_read: assert property (regRead && regAddr == 8'h44 |=>
      regRdata == {$past(chan2GainTrimCode), 4'h0}) else $error("gain");
   a_vol_read: assert property (regRead && regAddr == 8'h43 |=> regRdata == $past(chan2VolumeCode)) else $error("vol");
   a_phase_read: assert property (regRead && regAddr == 8'h45 |=> regRdata == $past(chan2PhaseDelayCode)) else $error("ph");
   // register lands one edge after the write, the decoded enable one edge later still
   a_ch2_source: assert property (regWrite && regAddr == 8'h41 |-> ##3
      {2{$past(regWdata[6:5], 3) == 2'h2}} == {chan2Enable, chan2UsesDataLine1}) else $error("src2");
   a_ch3_source: assert property (regWrite && regAddr == 8'h46 |-> ##3
      {2{$past(regWdata[6:5], 3) == 2'h2}} == {chan3Enable, chan3UsesDataLine2}) else $error("src3");
   a_ch2_mute: assert property (chan2Mute == ($past(chan2VolumeCode) == 8'h00)) else $error("mute2");
   a_ch3_mute: assert property (chan3Mute == ($past(chan3VolumeCode) == 8'h00)) else $error("mute3");
endmodule
bind pcr_channel_config_regs pcr_sva u_sva (.*);

// ==== testbench.sv ====
// self-checking bench for the channel 2/3 configuration bank
`timescale 1ns/1ps
module testbench;
   logic core_clk = 0, nrst = 0, regWrite = 0, regRead = 0, rdPend = 0;
   logic [7:0] regAddr = 0, regWdata = 0, regRdata, chan2VolumeCode, chan2PhaseDelayCode, chan3VolumeCode, w;
   logic [3:0] chan2GainTrimCode;
   logic chan2Enable, chan2UsesDataLine1, chan2Mute, chan3Enable, chan3UsesDataLine2, chan3Mute, pdmClockNeeded;
   logic [7:0] q[$];
   int bad_count = 0, num_checks = 0, seed = 32'h2a94;
   logic [7:0] ad[8] = '{8'h41, 8'h43, 8'h44, 8'h45, 8'h46, 8'h48, 8'h42, 8'h47};
   logic [7:0] rv[8] = '{8'h00, 8'hc9, 8'h80, 8'h00, 8'h00, 8'hc9, 8'h00, 8'h00};
   // unmapped places keep nothing, so their mask is zero
   logic [7:0] mk[8] = '{8'h60, 8'hff, 8'hf0, 8'hff, 8'h60, 8'hff, 8'h00, 8'h00};
   pcr_channel_config_regs u_dut (.*);
   task automatic check(logic [7:0] got, logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // strobes set in every bus task (wr, rd, idle), so none is assigned twice in one step
   task automatic wr(logic [7:0] a, logic [7:0] d);
      {regWrite, regRead, regAddr, regWdata} <= {2'b10, a, d};
      @(posedge core_clk);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      {regWrite, regRead, regAddr} <= {2'b01, a};
      q.push_back(e);
      @(posedge core_clk);
   endtask
   task automatic idle(int n);
      {regWrite, regRead} <= 2'b00;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge core_clk) rdPend <= regRead;
   always @(negedge core_clk) if (rdPend) check(regRdata, q.pop_front());
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      #5000;
      bad_count++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      foreach (ad[i]) rd(ad[i], rv[i]);
      foreach (ad[i]) begin
         w = 8'($random(seed));
         wr(ad[i], w);
         rd(ad[i], w & mk[i]);
      end
      for (int c = 0; c < 4; c++) begin
         wr(8'h41, {1'b1, 2'(c), 5'h1f});
         wr(8'h46, {1'b1, 2'(c), 5'h1f});
         idle(3);
         // look at settled outputs, away from the launching edge
         @(negedge core_clk);
         check({chan2Enable, chan2UsesDataLine1}, {6'h0, {2{c == 2}}});
         check({chan3Enable, chan3UsesDataLine2, pdmClockNeeded}, {5'h0, {3{c == 2}}});
         @(posedge core_clk);
      end
      wr(8'h43, 8'h00);
      wr(8'h48, 8'h00);
      wr(8'h44, 8'h5a);
      wr(8'h45, 8'h3c);
      idle(3);
      @(negedge core_clk);
      check({chan2Mute, chan3Mute}, 8'h03);
      check(chan2VolumeCode, 8'h00);
      check(chan3VolumeCode, 8'h00);
      check({4'h0, chan2GainTrimCode}, 8'h05);
      check(chan2PhaseDelayCode, 8'h3c);
      @(posedge core_clk);
      idle(2);
      finish_test();
   end
endmodule
